// ===== src/ccfsf_pkg.sv
// ccfsf_pkg: shared constants and carrier types of the fifo status block
// assumes: a 32-bit apb slave, register words at aligned byte offsets
package ccfsf_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_PF_ASSERT = 8'h04;
	localparam logic [7:0] OFF_PF_NEGATE = 8'h08;
	localparam logic [7:0] OFF_PE_ASSERT = 8'h0C;
	localparam logic [7:0] OFF_PE_NEGATE = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;

	// ****************************************************************
	// widths and reset values
	// ****************************************************************
	localparam int TH_W = 16;
	localparam logic [15:0] PF_ASSERT_RST = 16'h000C;
	localparam logic [15:0] PF_NEGATE_RST = 16'h000B;
	localparam logic [15:0] PE_ASSERT_RST = 16'h0004;
	localparam logic [15:0] PE_NEGATE_RST = 16'h0005;
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [4:0] FLAGS_RST = 5'h12;

	// ****************************************************************
	// carrier types
	// ****************************************************************
	// control word, low bits of the ctrl register
	typedef struct packed {
		logic ecc_en;
		logic pe_split;
		logic pf_split;
		logic soft_rst;
	} ccfsf_ctrl_t;

	// fifo level flags
	typedef struct packed {
		logic prog_empty;
		logic prog_full;
		logic almost_empty;
		logic empty;
		logic full;
	} ccfsf_flags_t;

	// status register layout, 32 bits
	typedef struct packed {
		logic [15:0] count;
		logic [7:0] rsvd;
		logic sleep;
		logic rd_busy;
		logic wr_busy;
		ccfsf_flags_t flags;
	} ccfsf_status_t;

endpackage : ccfsf_pkg

// ===== src/ccfsf_fifo.sv
// ccfsf_fifo: single-clock fifo with handshake, level flags, secded and apb control
// assumes: all user inputs come from logic on pclk, so none is synchronised;
// thresholds and ecc mode are written over apb and take effect through a fifo reset

module ccfsf_fifo #(
	parameter int DW = 8,
	parameter int DEPTH = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic srst,
	input wire logic [DW-1:0] din,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic inject_sbit,
	input wire logic inject_dbit,
	input wire logic sleep,
	output logic [DW-1:0] dout,
	output logic valid,
	output logic wr_ack,
	output logic overflow,
	output logic underflow,
	output ccfsf_pkg::ccfsf_flags_t flags,
	output logic sbiterr,
	output logic dbiterr,
	output logic wr_rst_busy,
	output logic rd_rst_busy
);

	// ****************************************************************
	// sizes and secded helpers
	// ****************************************************************
	localparam int AW = $clog2(DEPTH);
	localparam int TW = ccfsf_pkg::TH_W;

	// fewest check bits for a hamming code over d data bits
	function automatic int calc_cw(input int d);
		int c;
		c = 1;
		while ((1 << c) < d + c + 1)
		begin
			c++;
		end
		return c;
	endfunction : calc_cw

	localparam int CW = calc_cw(DW);
	localparam int MW = DW + CW + 1;

	// syndrome of data bit j: the j-th code with two or more bits set
	function automatic logic [CW-1:0] dcode(input int j);
		int n;
		int k;
		logic [CW-1:0] r;
		n = 0;
		r = '0;
		for (k = 3; k < (1 << CW); k++)
		begin
			if ($countones(k) > 1)
			begin
				if (n == j)
					r = CW'(k);
				n++;
			end
		end
		return r;
	endfunction : dcode

	// check bits: xor of the codes of every set data bit
	function automatic logic [CW-1:0] chk_of(input logic [DW-1:0] d);
		logic [CW-1:0] r;
		int j;
		r = '0;
		for (j = 0; j < DW; j++)
		begin
			if (d[j])
				r = r ^ dcode(j);
		end
		return r;
	endfunction : chk_of

	// ****************************************************************
	// state
	// ****************************************************************
	logic [MW-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	ccfsf_pkg::ccfsf_flags_t flags_q;
	ccfsf_pkg::ccfsf_flags_t flags_d;
	ccfsf_pkg::ccfsf_ctrl_t ctrl_q;
	ccfsf_pkg::ccfsf_ctrl_t cfg_q;
	logic [TW-1:0] pf_as_r_q;
	logic [TW-1:0] pf_ng_r_q;
	logic [TW-1:0] pe_as_r_q;
	logic [TW-1:0] pe_ng_r_q;
	logic [TW-1:0] pf_as_q;
	logic [TW-1:0] pf_ng_q;
	logic [TW-1:0] pe_as_q;
	logic [TW-1:0] pe_ng_q;
	logic [DW-1:0] dout_q;
	logic valid_q;
	logic wr_ack_q;
	logic overflow_q;
	logic underflow_q;
	logic sbiterr_q;
	logic dbiterr_q;
	logic busy_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;

	// ****************************************************************
	// request qualification
	// ****************************************************************
	// sleep and reset both park the fifo: no request is taken or refused
	wire fifo_rst = srst | ctrl_q.soft_rst;
	wire live = ~fifo_rst & ~sleep;
	wire wr_ok = live & wr_en & ~flags_q.full;
	wire wr_bad = live & wr_en & flags_q.full;
	wire rd_ok = live & rd_en & ~flags_q.empty;
	wire rd_bad = live & rd_en & flags_q.empty;

	// ****************************************************************
	// pointers and count
	// ****************************************************************
	wire wp_end = wp_q == AW'(DEPTH - 1);
	wire rp_end = rp_q == AW'(DEPTH - 1);
	wire [AW-1:0] wp_nx = wp_end ? '0 : wp_q + AW'(1);
	wire [AW-1:0] rp_nx = rp_end ? '0 : rp_q + AW'(1);
	wire [AW:0] cnt_up = cnt_q + (AW + 1)'(1);
	wire [AW:0] cnt_dn = cnt_q - (AW + 1)'(1);

	// simultaneous accepted read and write keep the count
	assign cnt_d = (wr_ok & ~rd_ok) ? cnt_up :
		(rd_ok & ~wr_ok) ? cnt_dn : cnt_q;

	// ****************************************************************
	// level flags
	// ****************************************************************
	wire [TW-1:0] cnt_t = TW'(cnt_d);
	wire [TW-1:0] pf_ng_eff = cfg_q.pf_split ? pf_ng_q : pf_as_q;
	wire [TW-1:0] pe_ng_eff = cfg_q.pe_split ? pe_ng_q : pe_as_q;
	wire pf_set = cnt_t >= pf_as_q;
	wire pf_clr = cnt_t < pf_ng_eff;
	wire pe_set = cnt_t <= pe_as_q;
	wire pe_clr = cnt_t > pe_ng_eff;

	// hysteresis: between the two levels a flag holds its value
	assign flags_d.full = cnt_d == (AW + 1)'(DEPTH);
	assign flags_d.empty = cnt_d == '0;
	assign flags_d.almost_empty = cnt_d == (AW + 1)'(1);
	assign flags_d.prog_full = pf_set | (~pf_clr & flags_q.prog_full);
	assign flags_d.prog_empty = pe_set | (~pe_clr & flags_q.prog_empty);

	// ****************************************************************
	// secded encode with error injection
	// ****************************************************************
	// check bits cover clean data, so a flipped data bit shows as an error
	wire [CW-1:0] wr_chk = chk_of(din);
	wire wr_par = ^{wr_chk, din};
	wire inj_one = cfg_q.ecc_en & inject_sbit & ~inject_dbit;
	wire inj_two = cfg_q.ecc_en & inject_dbit;
	wire [DW-1:0] inj_mask = {{(DW - 2){1'b0}}, inj_two, inj_one | inj_two};
	wire [MW-1:0] wr_word = {wr_par, wr_chk, din ^ inj_mask};

	// ****************************************************************
	// secded decode of the word at the read pointer
	// ****************************************************************
	wire [MW-1:0] rd_word = mem_q[rp_q];
	wire [DW-1:0] rd_raw = rd_word[DW-1:0];
	wire [CW-1:0] syn = rd_word[DW +: CW] ^ chk_of(rd_raw);
	wire par_bad = ^rd_word;
	wire sb_hit = cfg_q.ecc_en & par_bad;
	wire db_hit = cfg_q.ecc_en & ~par_bad & (syn != '0);
	wire [DW-1:0] fix_bits;

	// one flip per data bit whose code matches the syndrome
	for (genvar j = 0; j < DW; j++)
	begin : g_fix
		assign fix_bits[j] = sb_hit & (syn == dcode(j));
	end

	wire [DW-1:0] rd_data = rd_raw ^ fix_bits;

	// ****************************************************************
	// apb decode
	// ****************************************************************
	wire apb_acc = psel & penable;
	wire apb_done = apb_acc & pready_q;
	wire apb_wr = apb_done & pwrite;
	wire sel_ctrl = paddr == ccfsf_pkg::OFF_CTRL;
	wire sel_pfa = paddr == ccfsf_pkg::OFF_PF_ASSERT;
	wire sel_pfn = paddr == ccfsf_pkg::OFF_PF_NEGATE;
	wire sel_pea = paddr == ccfsf_pkg::OFF_PE_ASSERT;
	wire sel_pen = paddr == ccfsf_pkg::OFF_PE_NEGATE;
	wire sel_st = paddr == ccfsf_pkg::OFF_STATUS;
	wire sel_hit = sel_ctrl | sel_pfa | sel_pfn | sel_pea | sel_pen | sel_st;
	ccfsf_pkg::ccfsf_status_t st_word;

	// status snapshot of the block's own state
	assign st_word.count = TW'(cnt_q);
	assign st_word.rsvd = 8'h00;
	assign st_word.sleep = sleep;
	assign st_word.rd_busy = busy_q;
	assign st_word.wr_busy = busy_q;
	assign st_word.flags = flags_q;

	// read mux; unmapped addresses read as zero
	wire [31:0] rd_mux = sel_ctrl ? {28'h0000000, ctrl_q} :
		sel_pfa ? {16'h0000, pf_as_r_q} :
		sel_pfn ? {16'h0000, pf_ng_r_q} :
		sel_pea ? {16'h0000, pe_as_r_q} :
		sel_pen ? {16'h0000, pe_ng_r_q} :
		sel_st ? st_word : 32'h00000000;

	// ****************************************************************
	// apb slave timing
	// ****************************************************************
	// one wait state: pready rises on the second access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end
		else if (ce)
		begin
			pready_q <= apb_acc & ~pready_q;
			pslverr_q <= apb_acc & ~pready_q & ~sel_hit;
			prdata_q <= (apb_acc & ~pready_q & ~pwrite) ? rd_mux : 32'h00000000;
		end
	end

	// ****************************************************************
	// software registers
	// ****************************************************************
	// writes land on the edge where the master sees pready high
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= ccfsf_pkg::CTRL_RST;
			pf_as_r_q <= ccfsf_pkg::PF_ASSERT_RST;
			pf_ng_r_q <= ccfsf_pkg::PF_NEGATE_RST;
			pe_as_r_q <= ccfsf_pkg::PE_ASSERT_RST;
			pe_ng_r_q <= ccfsf_pkg::PE_NEGATE_RST;
		end
		else if (ce && apb_wr)
		begin
			if (sel_ctrl)
				ctrl_q <= pwdata[3:0];
			if (sel_pfa)
				pf_as_r_q <= pwdata[TW-1:0];
			if (sel_pfn)
				pf_ng_r_q <= pwdata[TW-1:0];
			if (sel_pea)
				pe_as_r_q <= pwdata[TW-1:0];
			if (sel_pen)
				pe_ng_r_q <= pwdata[TW-1:0];
		end
	end

	// ****************************************************************
	// threshold and mode capture
	// ****************************************************************
	// taken only while the fifo is in reset, so flags never see a
	// threshold change in mid-flight
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_q <= ccfsf_pkg::CTRL_RST;
			pf_as_q <= ccfsf_pkg::PF_ASSERT_RST;
			pf_ng_q <= ccfsf_pkg::PF_NEGATE_RST;
			pe_as_q <= ccfsf_pkg::PE_ASSERT_RST;
			pe_ng_q <= ccfsf_pkg::PE_NEGATE_RST;
		end
		else if (ce && fifo_rst)
		begin
			cfg_q <= ctrl_q;
			pf_as_q <= pf_as_r_q;
			pf_ng_q <= pf_ng_r_q;
			pe_as_q <= pe_as_r_q;
			pe_ng_q <= pe_ng_r_q;
		end
	end

	// ****************************************************************
	// storage
	// ****************************************************************
	// no reset on the array; a refused write never reaches it
	always_ff @(posedge pclk)
	begin
		if (ce && wr_ok)
			mem_q[wp_q] <= wr_word;
	end

	// ****************************************************************
	// pointers, count and flags
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			flags_q <= ccfsf_pkg::FLAGS_RST;
		end
		else if (ce && fifo_rst)
		begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			flags_q <= ccfsf_pkg::FLAGS_RST;
		end
		else if (ce && live)
		begin
			wp_q <= wr_ok ? wp_nx : wp_q;
			rp_q <= rd_ok ? rp_nx : rp_q;
			cnt_q <= cnt_d;
			flags_q <= flags_d;
		end
	end

	// ****************************************************************
	// handshake pulses and read data
	// ****************************************************************
	// ack and overflow are exclusive since full picks one of them
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_ack_q <= 1'b0;
			overflow_q <= 1'b0;
			underflow_q <= 1'b0;
			valid_q <= 1'b0;
			sbiterr_q <= 1'b0;
			dbiterr_q <= 1'b0;
			dout_q <= '0;
		end
		else if (ce)
		begin
			wr_ack_q <= wr_ok;
			overflow_q <= wr_bad;
			underflow_q <= rd_bad;
			valid_q <= rd_ok;
			sbiterr_q <= rd_ok & sb_hit;
			dbiterr_q <= rd_ok & db_hit;
			dout_q <= rd_ok ? rd_data : dout_q;
		end
	end

	// ****************************************************************
	// reset busy
	// ****************************************************************
	// high from power-on reset and through every fifo reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			busy_q <= 1'b1;
		else if (ce)
			busy_q <= fifo_rst;
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign dout = dout_q;
	assign valid = valid_q;
	assign wr_ack = wr_ack_q;
	assign overflow = overflow_q;
	assign underflow = underflow_q;
	assign flags = flags_q;
	assign sbiterr = sbiterr_q;
	assign dbiterr = dbiterr_q;
	assign wr_rst_busy = busy_q;
	assign rd_rst_busy = busy_q;

endmodule : ccfsf_fifo

// ===== sim/ccfsf_user.sv
// ccfsf_user: user logic that writes and reads the fifo on pclk
// assumes: mode comes from the bench, changed just after a rising edge
module ccfsf_user #(
	parameter int DW = 8
) (
	input wire logic pclk,
	input wire logic [1:0] mode,
	output logic [DW-1:0] din,
	output logic wr_en,
	output logic rd_en
);
	timeunit 1ns;
	timeprecision 1ns;
	int seed = 32'h0B5D;
	logic [31:0] r;
	// one process drives every output; the bench holds reset past the first edge
	// mode 1 writes, 2 reads, 3 mixes; din moves every cycle so stale data shows
	always @(posedge pclk)
	begin
		r = $random(seed);
		din <= r[DW-1:0];
		wr_en <= mode[0] && (mode != 2'h3 || r[DW]);
		rd_en <= mode[1] && (mode != 2'h3 || r[DW+1]);
	end
endmodule : ccfsf_user

// ===== sim/ccfsf_fifo_assertions.sv
// ccfsf_fifo_assertions: timing checks on the fifo handshake and flag ports
// assumes: bound into ccfsf_fifo, all ports sampled at the rising edge of pclk
module ccfsf_fifo_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic srst,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic sleep,
	input wire ccfsf_pkg::ccfsf_flags_t flags,
	input wire logic wr_ack,
	input wire logic overflow,
	input wire logic underflow,
	input wire logic valid,
	input wire logic sbiterr,
	input wire logic dbiterr,
	input wire logic wr_rst_busy,
	input wire logic rd_rst_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ****************************************************************
	// request outcomes
	// ****************************************************************
	// soft reset is hidden at the ports; busy one edge later rules it out
	wire logic go = ce && !sleep && !srst && !wr_rst_busy;
	property p_ack;
		go && wr_en && !flags.full ##1 !wr_rst_busy |-> wr_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("write taken, no ack");
	property p_ovf;
		go && wr_en && flags.full ##1 !wr_rst_busy |-> overflow && !wr_ack;
	endproperty
	a_ovf: assert property (p_ovf) else $error("full write, no overflow");
	property p_one_of;
		$past(ce) && (wr_ack || overflow) |-> !(wr_ack && overflow) && $past(wr_en);
	endproperty
	a_one_of: assert property (p_one_of) else $error("bad write pulse");
	property p_keep;
		go && flags.full && wr_en && !rd_en ##1 !wr_rst_busy |-> flags.full;
	endproperty
	a_keep: assert property (p_keep) else $error("refused write moved level");
	property p_uf;
		go && rd_en && flags.empty ##1 !rd_rst_busy |-> underflow && !valid;
	endproperty
	a_uf: assert property (p_uf) else $error("empty read, no underflow");
	property p_val;
		go && rd_en && !flags.empty ##1 !rd_rst_busy |-> valid;
	endproperty
	a_val: assert property (p_val) else $error("read taken, no valid");
	property p_rd_cause;
		$past(ce) && (valid || underflow) |-> !(valid && underflow) && $past(rd_en);
	endproperty
	a_rd_cause: assert property (p_rd_cause) else $error("bad read pulse");
	property p_one_word;
		go && flags.almost_empty && rd_en && !wr_en ##1 !rd_rst_busy |-> flags.empty;
	endproperty
	a_one_word: assert property (p_one_word) else $error("last word read, not empty");
	property p_busy;
		ce && srst |=> wr_rst_busy && rd_rst_busy;
	endproperty
	a_busy: assert property (p_busy) else $error("reset without busy");
	property p_sleep;
		ce && sleep && !srst ##1 !wr_rst_busy |-> !wr_ack && !valid && $stable(flags);
	endproperty
	a_sleep: assert property (p_sleep) else $error("activity while asleep");
	property p_ecc;
		sbiterr || dbiterr |-> valid;
	endproperty
	a_ecc: assert property (p_ecc) else $error("ecc flag without valid");
	c_ovf: cover property (overflow);
	c_uf: cover property (underflow);
	c_sbit: cover property (sbiterr);
	c_dbit: cover property (dbiterr);
endmodule : ccfsf_fifo_assertions
bind ccfsf_fifo ccfsf_fifo_assertions u_chk (
	.pclk(pclk),
	.presetn(presetn),
	.ce(ce),
	.srst(srst),
	.wr_en(wr_en),
	.rd_en(rd_en),
	.sleep(sleep),
	.flags(flags),
	.wr_ack(wr_ack),
	.overflow(overflow),
	.underflow(underflow),
	.valid(valid),
	.sbiterr(sbiterr),
	.dbiterr(dbiterr),
	.wr_rst_busy(wr_rst_busy),
	.rd_rst_busy(rd_rst_busy)
);

// ===== sim/ccfsf_fifo_bench.sv
// ccfsf_fifo_bench: self-checking bench of the fifo status block
// assumes: design, user model and bound checker compiled before this file
module ccfsf_fifo_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DEPTH = 16;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = '0, din, dout;
	logic [31:0] pwdata = '0, prdata, rd, r;
	logic srst = 1'b0, sleep = 1'b0, inject_sbit = 1'b0, inject_dbit = 1'b0;
	logic [1:0] mode = 2'h0;
	logic pready, pslverr, wr_en, rd_en, valid, wr_ack, overflow, underflow;
	logic sbiterr, dbiterr, wr_rst_busy, rd_rst_busy, er, frst, ecc;
	logic e_ack, e_ovf, e_uf, e_val, e_busy;
	ccfsf_pkg::ccfsf_flags_t flags, e_flags;
	logic [9:0] e_w, q[$];
	logic [15:0] rg [5], pfa, pfn, pea, pen;
	int seed = 32'h0B5D;
	int n_fail = 0, n_compared = 0;
	int c;
	ccfsf_fifo #(.DW(8), .DEPTH(DEPTH)) u_dut (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.paddr(paddr),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.srst(srst),
		.din(din),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.inject_sbit(inject_sbit),
		.inject_dbit(inject_dbit),
		.sleep(sleep),
		.dout(dout),
		.valid(valid),
		.wr_ack(wr_ack),
		.overflow(overflow),
		.underflow(underflow),
		.flags(flags),
		.sbiterr(sbiterr),
		.dbiterr(dbiterr),
		.wr_rst_busy(wr_rst_busy),
		.rd_rst_busy(rd_rst_busy)
	);
	ccfsf_user #(.DW(8)) u_user (
		.pclk(pclk),
		.mode(mode),
		.din(din),
		.wr_en(wr_en),
		.rd_en(rd_en)
	);
	// ****************************************************************
	// clock, checks and bus tasks
	// ****************************************************************
	// 50 MHz
	always #10 pclk = ~pclk;
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			n_fail++;
			$display("BAD t=%0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task tally_and_finish();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	// one apb transfer, held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do
			@(posedge pclk);
		while (pready !== 1'b1 && ++i < 50);
		// a slave that never answers counts once; the run goes on to the report
		if (pready !== 1'b1)
			n_fail++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// every word of the map against the bench's own copy
	task automatic check_map();
		for (int k = 0; k < 6; k++)
		begin
			apb(1'b0, 8'(k * 4), 32'h0);
			chk(rd, k < 5 ? 32'(rg[k]) : {16'(q.size()), 8'h00, sleep, e_busy, e_busy, e_flags});
			chk(32'(er), 32'h0);
		end
	endtask : check_map
	// traffic of one mode; injection drawn at random, sleep drawn at random in mixed traffic only, sleep ends low
	task automatic run(input logic [1:0] m, input int n);
		@(posedge pclk);
		mode <= m;
		for (int i = 1; i <= n; i++)
		begin
			@(posedge pclk);
			r = $random(seed);
			sleep <= m == 2'h3 && r[2:0] == 3'h0 && i < n;
			// clock enable drops now and then in mixed traffic, so frozen state is compared too
			ce <= m != 2'h3 || r[8:6] != 3'h0 || i == n;
			inject_sbit <= r[3];
			inject_dbit <= r[4] & r[5];
		end
	endtask : run
	// ****************************************************************
	// reference model
	// ****************************************************************
	// level flags from the new count, thresholds hold between their levels
	function automatic ccfsf_pkg::ccfsf_flags_t nf(input int n, input ccfsf_pkg::ccfsf_flags_t o);
		nf = o;
		nf.full = n == DEPTH;
		nf.empty = n == 0;
		nf.almost_empty = n == 1;
		if (n >= pfa)
			nf.prog_full = 1'b1;
		else if (n < pfn)
			nf.prog_full = 1'b0;
		if (n <= pea)
			nf.prog_empty = 1'b1;
		else if (n > pen)
			nf.prog_empty = 1'b0;
	endfunction : nf
	// expected outputs one edge after each request; fifo reset copies thresholds
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			q.delete();
			{e_ack, e_ovf, e_uf, e_val} = 4'h0;
			e_flags = 5'h12;
			e_busy = 1'b1;
			rg = '{16'h0000, 16'h000C, 16'h000B, 16'h0004, 16'h0005};
			{pfa, pfn, pea, pen, ecc} = {16'h000C, 16'h000C, 16'h0004, 16'h0004, 1'b0};
		end
		else if (ce)
		begin
			frst = srst | rg[0][0];
			e_busy = frst;
			{e_ack, e_ovf, e_uf, e_val} = 4'h0;
			if (frst)
			begin
				q.delete();
				e_flags = 5'h12;
				pfa = rg[1];
				pfn = rg[0][1] ? rg[2] : rg[1];
				pea = rg[3];
				pen = rg[0][2] ? rg[4] : rg[3];
				ecc = rg[0][3];
			end
			else if (!sleep)
			begin
				e_val = rd_en && q.size() > 0;
				e_ack = wr_en && q.size() < DEPTH;
				e_uf = rd_en && !e_val;
				e_ovf = wr_en && !e_ack;
				if (e_val)
					e_w = q.pop_front();
				if (e_ack)
					q.push_back({ecc & inject_dbit, ecc & inject_sbit & !inject_dbit, din});
				e_flags = nf(q.size(), e_flags);
			end
			if (psel && penable && pready && pwrite && paddr < 8'h14)
				rg[paddr[4:2]] = pwdata[15:0] & (paddr == 8'h00 ? 16'h000F : 16'hFFFF);
		end
	end
	// compare at the falling edge, where every output has settled
	always @(negedge pclk)
	begin
		chk(32'({wr_ack, overflow, underflow, valid}), 32'({e_ack, e_ovf, e_uf, e_val}));
		chk(32'(flags), 32'(e_flags));
		chk(32'({wr_rst_busy, rd_rst_busy}), 32'({e_busy, e_busy}));
		if (e_val)
		begin
			chk(32'({sbiterr, dbiterr}), 32'({e_w[8], e_w[9]}));
			if (!e_w[9])
				chk(32'(dout), 32'(e_w[7:0]));
		end
	end
	// hang guard
	initial
	begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		tally_and_finish();
	end
	// reset, map, default levels, then split and ecc modes, then a second reset
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check_map();
		run(2'h1, DEPTH + 2);
		run(2'h3, 60);
		run(2'h2, DEPTH + 2);
		for (c = 0; c < 6; c++)
			apb(1'b1, 8'(c * 4), $random(seed) & (c == 0 ? 32'hFFFFFFFE : 32'hFFFFFFFF));
		check_map();
		apb(1'b0, 8'h18, 32'h0);
		chk(32'(er), 32'h1);
		chk(rd, 32'h0);
		for (c = 0; c < 4; c++)
		begin
			apb(1'b1, 8'h04, 32'(9 + c));
			apb(1'b1, 8'h08, 32'h5);
			apb(1'b1, 8'h0C, 32'h3);
			apb(1'b1, 8'h10, 32'(7 - c));
			apb(1'b1, 8'h00, 32'(c * 2 + 9));
			apb(1'b1, 8'h00, 32'(c * 2 + 8));
			run(2'h1, DEPTH + 2);
			run(2'h3, 100);
			@(posedge pclk);
			srst <= 1'b1;
			repeat (2) @(posedge pclk);
			srst <= 1'b0;
			run(2'h3, 40);
			run(2'h2, DEPTH + 2);
		end
		@(posedge pclk);
		mode <= 2'h0;
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		run(2'h3, 40);
		tally_and_finish();
	end
endmodule : ccfsf_fifo_bench
